// ===== rtl/hbi_pkg.sv
// Constants and types for the synchronous host bus slave port.
// Assumes one core clock domain; host pins arrive asynchronously.
// Summary of operation
// - 16-bit data, 21 address inputs, no glue
// - Host bit numbering reversed onto device pins
// - Interface type latched from straps at reset release
// - Lock bit set at reset limits registers
// - Memory/register select steers each access
// - Burst inhibit driven on high write-enable pin with each acknowledge
// - Wait holds host until data ready/accepted
// - Host port timed by separate bus clock
// - Transfer acknowledge lasts one bus clock
// - Every transaction lasts two bus clocks minimum
// - Halfword uses 16 lines, ignores address bit 0
package hbi_pkg;
  localparam int HBI_ADDR_W = 21;
  localparam int HBI_DATA_W = 16;
  localparam int HBI_REG_W = 8;
  localparam int HBI_STRAP_W = 4;
  localparam logic [20:0] HBI_REG_IDENT_OFS = 21'h000000;
  localparam logic [20:0] HBI_REG_MISC_OFS = 21'h000001;
  localparam int HBI_MISC_LOCK_BIT = 7;
  localparam logic [7:0] HBI_MISC_RESET = 8'h80;
  // Transfer size codes as {TSIZ0, TSIZ1}
  localparam logic [1:0] HBI_TSIZ_BYTE = 2'h1;
  // Snapshot vector layout: data, address, then six control bits
  localparam int HBI_SNAP_W = HBI_DATA_W + HBI_ADDR_W + 6;
  typedef enum logic [2:0] {
    HBI_IDLE = 3'b000,
    HBI_WDATA = 3'b001,
    HBI_ACCESS = 3'b010,
    HBI_ACKWAIT = 3'b011,
    HBI_ACKHOLD = 3'b100
  } hbi_state_type;
endpackage

// ===== rtl/hbi_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes each bit is sampled independently; only stage two is read.
`timescale 1ns/1ps
`default_nettype none
module hbi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // hbi_sync
`default_nettype wire

// ===== rtl/hbi_host_port.sv
// Synchronous host bus slave port with reset-time lock register.
// Assumes the bus clock is several core clocks long and that the
// display side answers back-end requests with a one-cycle backAck.
`timescale 1ns/1ps
`default_nettype none
module hbi_host_port #(
  parameter logic [3:0] STRAP_SYNC_BE = 4'h0, // Arbitrary strap code
  parameter logic [7:0] IDENT_VALUE = 8'h5A // Arbitrary ident value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hostInterfaceClock,
  input wire logic [hbi_pkg::HBI_ADDR_W-1:0] hostAddrIn,
  input wire logic [hbi_pkg::HBI_DATA_W-1:0] hostDataIn,
  output logic [hbi_pkg::HBI_DATA_W-1:0] hostDataOut,
  output logic hostDataOeN,
  input wire logic memRegSelect,
  input wire logic chipSelectN,
  input wire logic readWriteN,
  input wire logic tsize0N,
  input wire logic lowWriteEnablePinN,
  input wire logic busStartN,
  output logic waitN,
  output logic highWriteEnableBurstInhibitPinN,
  input wire logic [hbi_pkg::HBI_STRAP_W-1:0] strapConfigInputs,
  output logic hostIfEnabled,
  output logic [hbi_pkg::HBI_REG_W-1:0] miscRegOut,
  input wire logic displayArbBusy,
  output logic backReq,
  output logic backMemSel,
  output logic [hbi_pkg::HBI_ADDR_W-1:0] backAddr,
  output logic backWrite,
  output logic [1:0] backByteEn,
  output logic [hbi_pkg::HBI_DATA_W-1:0] backWrData,
  input wire logic [hbi_pkg::HBI_DATA_W-1:0] backRdData,
  input wire logic backAck
);
  import hbi_pkg::*;

  logic [HBI_SNAP_W-1:0] pinsSync;
  logic busClkSync, busClkPrev_q, busRise, busFall;
  logic [HBI_SNAP_W-1:0] snap_q;
  logic sBsN, sCsN, sRdWrN, sMr;
  logic [1:0] sTsiz;
  logic [HBI_ADDR_W-1:0] sAddr;
  logic [HBI_DATA_W-1:0] sData;
  hbi_state_type st_q, st_d;
  logic strapValid_q;
  logic [HBI_STRAP_W-1:0] strapCode_q;
  logic [HBI_REG_W-1:0] misc_q;
  logic isWrite_q, isMem_q;
  logic [HBI_ADDR_W-1:0] addr_q;
  logic [1:0] be_q;
  logic [HBI_DATA_W-1:0] wrData_q, rdData_q;
  logic backReq_q;
  logic waitN_q, oeN_q;
  logic startHit, lockOn, regLow, internalHit, blocked, needBack;
  logic [1:0] beDecode;
  logic [HBI_DATA_W-1:0] regRead;

  // Bus clock and every host pin pass two flops before use
  // the bus clock is only sampled, so it must stay slow against clk.
  hbi_sync #(.WIDTH(HBI_SNAP_W + 1)) uSync (
    .clk(clk),
    .rst(rst),
    .asyncIn({hostInterfaceClock, hostDataIn, hostAddrIn, busStartN,
              chipSelectN, readWriteN, memRegSelect, tsize0N,
              lowWriteEnablePinN}),
    .syncOut({busClkSync, pinsSync})
  );

  // Edge finding on the sampled bus clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busClkPrev_q <= 1'b0;
    end else begin
      busClkPrev_q <= busClkSync;
    end
  end
  assign busRise = busClkSync & ~busClkPrev_q;
  assign busFall = ~busClkSync & busClkPrev_q;

  // Host outputs move on its rising edge, so pins are snapshotted
  // mid-cycle at the falling edge and judged at the next rise.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_q <= '1;
    end else if (busFall) begin
      snap_q <= pinsSync;
    end
  end
  assign {sData, sAddr, sBsN, sCsN, sRdWrN, sMr} = snap_q[HBI_SNAP_W-1:2];
  assign sTsiz = snap_q[1:0];

  // Interface type caught on the first edge after reset release
  // until then, and for any other strap code, the port stays silent.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapValid_q <= 1'b0;
      strapCode_q <= '0;
    end else if (!strapValid_q) begin
      strapValid_q <= 1'b1;
      strapCode_q <= strapConfigInputs;
    end
  end
  assign hostIfEnabled = strapValid_q && (strapCode_q == STRAP_SYNC_BE);

  // Access starts on a bus rise with start strobe and select low
  assign startHit = busRise && hostIfEnabled && !sBsN && !sCsN;

  // Halfword uses both lanes and ignores address bit 0
  // a byte picks the high lane at even addresses (big-endian).
  assign beDecode = (sTsiz == HBI_TSIZ_BYTE) ?
                    (sAddr[0] ? 2'h1 : 2'h2) : 2'h3;

  // Decode of the locked register window
  assign lockOn = misc_q[HBI_MISC_LOCK_BIT];
  assign regLow = !isMem_q && (addr_q[HBI_ADDR_W-1:1] ==
                               HBI_REG_IDENT_OFS[HBI_ADDR_W-1:1]);
  assign internalHit = regLow;
  assign blocked = lockOn && !regLow;
  assign needBack = !internalHit && !blocked;
  assign regRead = {IDENT_VALUE, misc_q};

  // Sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      HBI_IDLE: begin
        if (startHit) begin
          st_d = sRdWrN ? HBI_ACCESS : HBI_WDATA;
        end
      end
      HBI_WDATA: begin
        if (busFall) begin
          st_d = HBI_ACCESS;
        end
      end
      HBI_ACCESS: begin
        if (!needBack || backAck) begin
          st_d = HBI_ACKWAIT;
        end
      end
      HBI_ACKWAIT: begin
        if (busFall) begin
          st_d = HBI_ACKHOLD;
        end
      end
      HBI_ACKHOLD: begin
        if (busFall) begin
          st_d = HBI_IDLE;
        end
      end
      default: st_d = HBI_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= HBI_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Access capture; write data is taken at the bus fall after the start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isWrite_q <= 1'b0;
      isMem_q <= 1'b0;
      addr_q <= '0;
      be_q <= '0;
      wrData_q <= '0;
    end else if (st_q == HBI_IDLE && startHit) begin
      isWrite_q <= !sRdWrN;
      isMem_q <= sMr;
      addr_q <= sAddr;
      be_q <= beDecode;
    end else if (st_q == HBI_WDATA && busFall) begin
      wrData_q <= pinsSync[HBI_SNAP_W-1:HBI_ADDR_W+6];
    end
  end

  // Lock set by reset, changed only by a low-lane write to register address 0 or 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      misc_q <= HBI_MISC_RESET;
    end else if (st_q == HBI_ACCESS && regLow && isWrite_q && be_q[0]) begin
      misc_q <= wrData_q[HBI_REG_W-1:0];
    end
  end
  assign miscRegOut = misc_q;

  // Back-end request waits out display arbitration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      backReq_q <= 1'b0;
    end else if (backAck) begin
      backReq_q <= 1'b0;
    end else if (st_q == HBI_ACCESS && needBack && !displayArbBusy) begin
      backReq_q <= 1'b1;
    end
  end
  assign backReq = backReq_q;
  assign backMemSel = isMem_q;
  assign backAddr = addr_q;
  assign backWrite = isWrite_q;
  assign backByteEn = be_q;
  assign backWrData = wrData_q;

  // Read data: blocked reads return zero, writes return nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (st_q == HBI_ACCESS && st_d == HBI_ACKWAIT) begin
      rdData_q <= internalHit ? regRead : (blocked ? '0 : backRdData);
    end
  end

  // Acknowledge changes on bus falls, so the host sees exactly one rising
  // edge with it low; drive starts once read data is captured, ends on a fall.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitN_q <= 1'b1;
      oeN_q <= 1'b1;
    end else begin
      waitN_q <= !(st_d == HBI_ACKHOLD);
      oeN_q <= !(!isWrite_q && (st_d == HBI_ACKWAIT ||
                                st_d == HBI_ACKHOLD));
    end
  end
  assign waitN = waitN_q;
  // No bursts: inhibit goes out with every acknowledge.
  assign highWriteEnableBurstInhibitPinN = waitN_q;
  assign hostDataOut = rdData_q;
  assign hostDataOeN = oeN_q;

  // Checking helpers: rises seen while acknowledging and since start
  logic [3:0] riseInAck_q, riseSinceStart_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      riseInAck_q <= '0;
      riseSinceStart_q <= '0;
    end else begin
      if (waitN_q) riseInAck_q <= '0;
      else if (busRise) riseInAck_q <= riseInAck_q + 4'h1;
      // The start rise itself is the first bus clock of the transaction
      if (st_q == HBI_IDLE) riseSinceStart_q <= startHit ? 4'h1 : 4'h0;
      else if (busRise && riseSinceStart_q != 4'hF)
        riseSinceStart_q <= riseSinceStart_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_wait_state: assert property (!waitN |-> st_q == HBI_ACKHOLD)
    else $error("wait low outside acknowledge");
  a_burst_with_ack: assert property (
    highWriteEnableBurstInhibitPinN == waitN)
    else $error("burst inhibit not paired with acknowledge");
  a_ack_one_rise: assert property ($rose(waitN) |->
    $past(riseInAck_q) == 4'h1)
    else $error("acknowledge not exactly one bus clock");
  a_min_two_clocks: assert property ($fell(waitN) |->
    riseSinceStart_q >= 4'h1)
    else $error("transaction shorter than two bus clocks");
  a_lock_blocks: assert property (backReq |-> !lockOn)
    else $error("back end reached while locked");
  a_req_after_arb: assert property ($rose(backReq) |->
    !$past(displayArbBusy))
    else $error("request raised during arbitration");
  a_strap_stable: assert property (strapValid_q && $past(strapValid_q)
    |-> $stable(strapCode_q))
    else $error("strap code changed after capture");
  a_start_gated: assert property (st_q == HBI_IDLE && st_d != HBI_IDLE
    |-> busRise && !sBsN && !sCsN ##1 st_q != HBI_IDLE)
    else $error("access started without strobe and select");
  a_drive_read: assert property (!hostDataOeN |-> !isWrite_q)
    else $error("data driven during write");

  c_read_ack: cover property (!isWrite_q && $fell(waitN));
  c_write_ack: cover property (isWrite_q && $fell(waitN));
  c_unlock: cover property ($fell(lockOn));
  c_arb_stall: cover property ((st_q == HBI_ACCESS && displayArbBusy) [*3]);
endmodule // hbi_host_port
`default_nettype wire

// ===== test/hbi_host_model.sv
// Host bus controller model: free-running bus clock and one access task.
// Assumes the bench resolves the shared data wire from the device enable alone.
`timescale 1ns/1ps
`default_nettype none
module hbi_host_model (
  output logic host_interface_clock,
  output logic [20:0] addr,
  output logic [15:0] drv,
  input wire logic [15:0] dataWire,
  output logic msel,
  output logic csN,
  output logic rwN,
  output logic tsz0N,
  output logic tsz1N,
  output logic tsN,
  input wire logic waitN,
  input wire logic oeN
);
  // Host system clock runs free, unrelated in phase to the core clock
  initial begin
    {addr, drv, msel} = '0;
    {csN, rwN, tsz0N, tsz1N, tsN} = 5'h1F;
    host_interface_clock = 1'b0;
    #37;
    forever #400 host_interface_clock = ~host_interface_clock;
  end
  // One access; held until the acknowledge is seen at a rising edge or 40 bus clocks pass
  task automatic access(input logic wr, input logic mem, input logic bytes,
    input logic [20:0] a, input logic [15:0] wd, output logic [15:0] rd,
    output logic ok, output int cyc, output logic oeAck, output logic wa);
    ok = 1'b0;
    cyc = 0;
    rd = 16'h0000;
    oeAck = 1'b1;
    @(posedge host_interface_clock);
    addr <= a;
    msel <= mem;
    // Select with the address: no delay, no early negate, relaxed
    // timing or extended hold is programmed.
    csN <= 1'b0;
    tsN <= 1'b0;
    rwN <= ~wr;
    {tsz0N, tsz1N} <= bytes ? 2'h1 : 2'h2;
    drv <= wr ? wd : ~drv;
    // No programmed wait states: the device ends the cycle.
    // Burst inhibit is left to the device, not auto-set here.
    while (!ok && cyc < 40) begin
      @(posedge host_interface_clock);
      tsN <= 1'b1;
      cyc++;
      if (waitN === 1'b0) begin
        ok = 1'b1;
        rd = dataWire;
        oeAck = oeN;
      end
    end
    // Released select, address and data show the inverse, never the last value
    csN <= 1'b1;
    rwN <= 1'b1;
    addr <= ~a;
    drv <= ~drv;
    @(posedge host_interface_clock);
    wa = waitN;
  endtask
endmodule // hbi_host_model
`default_nettype wire

// ===== test/hbi_host_port_tb.sv
// Testbench for the host bus slave port with a behavioural back end.
// Assumes the host model above; the back end answers after three cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin badCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module hbi_host_port_tb;
  import hbi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, busy = 1'b0, backAck = 1'b0;
  logic [3:0] strap = 4'h6;
  logic [15:0] backRdData = 16'h0000, hostDrv, dataWire, dOut, rd;
  logic [20:0] addr, backAddr, lastAddr;
  logic msel, csN, rwN, tsz0N, tsz1N, tsN, waitN, oeN, bi, ifEn, ok, oe, wa;
  logic backReq, backMemSel, backWrite, reqPrev = 1'b0, lastW, lastSel;
  logic [1:0] backByteEn, lastEn;
  logic [15:0] backWrData;
  logic [15:0] mem [logic [20:0]];
  logic [7:0] misc;
  logic host_interface_clock;
  int badCount = 0, cmpCount = 0, reqCnt = 0, biBad = 0, waitCnt = 0, cyc;
  // Core clock, 100 ns period
  always #50 clk = ~clk;
  // Data wire: device drives while its enable is low
  assign dataWire = oeN ? hostDrv : dOut;
  hbi_host_port #(.STRAP_SYNC_BE(4'h6), .IDENT_VALUE(8'hC3))
    hbi_host_port_inst (.clk(clk), .rst(rst), .hostInterfaceClock(host_interface_clock),
    .hostAddrIn(addr), .hostDataIn(dataWire), .hostDataOut(dOut),
    .hostDataOeN(oeN), .memRegSelect(msel), .chipSelectN(csN),
    .readWriteN(rwN), .tsize0N(tsz0N), .lowWriteEnablePinN(tsz1N),
    .busStartN(tsN), .waitN(waitN), .highWriteEnableBurstInhibitPinN(bi),
    .strapConfigInputs(strap), .hostIfEnabled(ifEn), .miscRegOut(misc),
    .displayArbBusy(busy), .backReq(backReq), .backMemSel(backMemSel),
    .backAddr(backAddr), .backWrite(backWrite), .backByteEn(backByteEn),
    .backWrData(backWrData), .backRdData(backRdData), .backAck(backAck));
  hbi_host_model hbi_host_model_inst (.host_interface_clock(host_interface_clock), .addr(addr),
    .drv(hostDrv), .dataWire(dataWire), .msel(msel), .csN(csN), .rwN(rwN),
    .tsz0N(tsz0N), .tsz1N(tsz1N), .tsN(tsN), .waitN(waitN), .oeN(oeN));
  // Back end: a fixed latency keeps the acknowledge timing predictable
  always @(posedge clk) begin
    backAck <= 1'b0;
    reqPrev <= backReq;
    if (backReq && !reqPrev) reqCnt++;
    if (!rst && bi !== waitN) biBad++;
    if (backReq && !backAck) begin
      if (waitCnt == 2) begin
        waitCnt <= 0;
        backAck <= 1'b1;
        backRdData <= mem.exists(backAddr) ? mem[backAddr] : 16'hFFFF;
        if (backWrite) mem[backAddr] = backWrData;
        {lastAddr, lastEn, lastW, lastSel} <=
          {backAddr, backByteEn, backWrite, backMemSel};
      end else waitCnt <= waitCnt + 1;
    end
  end
  task automatic resetDut(input logic [3:0] s);
    rst <= 1'b1;
    strap <= s;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  // One access with the common acknowledge checks
  task automatic xfer(input logic wr, input logic m, input logic b,
    input logic [20:0] a, input logic [15:0] d);
    hbi_host_model_inst.access(wr, m, b, a, d, rd, ok, cyc, oe, wa);
    `CHK(ok, 1'b1)
    `CHK(wa, 1'b1)
    `CHK(cyc > 0, 1'b1)
    if (!wr) begin
      `CHK(rd, d)
      `CHK(oe, 1'b0)
    end
  endtask
  task automatic closeOut;
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    resetDut(4'h9);
    `CHK(ifEn, 1'b0)
    hbi_host_model_inst.access(0, 0, 0, 21'h0, 16'h0, rd, ok, cyc, oe, wa);
    `CHK(ok, 1'b0)
    $display("test strap done");
    resetDut(4'h6);
    `CHK(ifEn, 1'b1)
    `CHK(misc, 8'h80)
    `CHK(oeN, 1'b1)
    xfer(0, 0, 0, 21'h0, 16'hC380);
    xfer(0, 1, 0, 21'h100, 16'h0000);
    xfer(1, 1, 0, 21'h100, 16'h1234);
    `CHK(reqCnt, 0)
    $display("test lock done");
    xfer(1, 0, 0, 21'h0, 16'hFF12);
    `CHK(misc, 8'h12)
    xfer(0, 0, 0, 21'h0, 16'hC312);
    $display("test unlock done");
    xfer(1, 1, 0, 21'h100, 16'hBEEF);
    `CHK({lastAddr, lastEn, lastW, lastSel}, {21'h100, 2'h3, 2'h3})
    @(posedge clk);
    busy <= 1'b1;
    fork
      begin
        repeat (60) @(posedge clk);
        busy <= 1'b0;
      end
    join_none
    xfer(0, 1, 0, 21'h100, 16'hBEEF);
    `CHK(cyc > 5, 1'b1)
    $display("test memory done");
    xfer(1, 1, 1, 21'h101, 16'h0077);
    `CHK(lastEn, 2'h1)
    xfer(1, 1, 1, 21'h104, 16'h7700);
    `CHK(lastEn, 2'h2)
    xfer(1, 1, 0, 21'h103, 16'h0102);
    `CHK(lastEn, 2'h3)
    `CHK(biBad, 0)
    $display("test lanes done");
    closeOut();
  end
  // Watchdog, well beyond the expected run of about 0.1 ms
  initial begin
    #3000000;
    badCount++;
    closeOut();
  end
endmodule // hbi_host_port_tb
`default_nettype wire
